// File: core/atc_ctrl.sv
// APB register file, conversion sequencer and result logic of the auxiliary converter
`timescale 1ns/1ns
module atc_ctrl (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output atc_pkg::atc_ana_s      ana,
    output logic                   ana_start,
    input  wire logic              ana_done,
    input  wire logic [7:0]        ana_code,
    output logic                   irq
);
    atc_pkg::atc_state_e state;
    atc_pkg::atc_state_e next_state;
    atc_pkg::atc_ana_s   next_ana;
    logic [6:0]          cfg;
    logic [3:0]          offs;
    logic [7:0]          result;
    logic [7:0]          cal;
    logic [7:0]          tvoffs;
    logic                done;
    logic [0:0]          status;
    logic [0:0]          mask;
    logic [31:0]         next_prdata;
    logic [7:0]          next_result;

    // Address decode, one aligned word per register
    wire        setup      = psel & ~penable;
    wire        wr_cycle   = psel & penable & pwrite;
    wire        aligned    = (paddr[1:0] == 2'b00);
    wire [5:0]  idx        = paddr[7:2];
    wire        hit_cfg    = aligned & (idx == atc_pkg::ATC_IDX_CFG);
    wire        hit_offs   = aligned & (idx == atc_pkg::ATC_IDX_OFFS);
    wire        hit_result = aligned & (idx == atc_pkg::ATC_IDX_RESULT);
    wire        hit_cal    = aligned & (idx == atc_pkg::ATC_IDX_CAL);
    wire        hit_tvoffs = aligned & (idx == atc_pkg::ATC_IDX_TVOFFS);
    wire        hit_status = aligned & (idx == atc_pkg::ATC_IDX_STATUS);
    wire        hit_mask   = aligned & (idx == atc_pkg::ATC_IDX_MASK);
    wire        hit_any    = hit_cfg | hit_offs | hit_result | hit_cal | hit_tvoffs
                             | hit_status | hit_mask;
    // Result is read-only, so a write to it is refused as well
    wire        bad_access = ~hit_any | (pwrite & hit_result);

    wire        wr_cfg     = wr_cycle & hit_cfg;
    wire        wr_offs    = wr_cycle & hit_offs;
    wire        wr_cal     = wr_cycle & hit_cal;
    wire        wr_tvoffs  = wr_cycle & hit_tvoffs;
    wire        wr_status  = wr_cycle & hit_status;
    wire        wr_mask    = wr_cycle & hit_mask;

    // A start while busy is dropped: the running conversion keeps its settings
    wire        start_req  = wr_cfg & pwdata[atc_pkg::ATC_CFG_START];
    wire        start_ok   = start_req & (state == atc_pkg::ATC_ST_IDLE);
    wire        conv_end   = (state == atc_pkg::ATC_ST_CONV) & ana_done;

    // Settings taken for the conversion: fresh write data wins over the old register
    wire [6:0]  cfg_use    = wr_cfg ? pwdata[6:0] : cfg;
    wire [2:0]  sel_use    = cfg_use[atc_pkg::ATC_SEL_LSB +: 3];
    wire [1:0]  ref_use    = cfg_use[atc_pkg::ATC_REF_LSB +: 2];
    wire [1:0]  gain_use   = cfg_use[atc_pkg::ATC_GAIN_LSB +: 2];
    wire [3:0]  offs_use   = wr_offs ? pwdata[3:0] : offs;
    wire [7:0]  cal_use    = wr_cal ? pwdata[7:0] : cal;

    // Temperature result with signed offset, saturated to the code range
    wire [9:0]  temp_sum   = {2'b00, ana_code} + {{2{tvoffs[7]}}, tvoffs};
    wire [7:0]  temp_sat   = temp_sum[9] ? 8'h00 : (temp_sum[8] ? 8'hff : temp_sum[7:0]);
    wire        is_temp    = (ana.src == atc_pkg::ATC_SRC_TEMP);

    always_comb begin
        next_result = is_temp ? temp_sat : ana_code;
    end

    always_comb begin
        next_ana              = ana;
        next_ana.src          = atc_pkg::atc_src_e'(sel_use);
        next_ana.diff_mode    = sel_use[2] & (sel_use != atc_pkg::ATC_SRC_GND);
        next_ana.ref_bandgap  = ~ref_use[1];
        next_ana.ref_third    = (ref_use == 2'b10);
        next_ana.ref_half     = (ref_use == 2'b11);
        next_ana.fs_coef_high = ref_use[0];
        next_ana.gain         = gain_use;
        next_ana.offs_mag     = offs_use[2:0];
        next_ana.offs_neg     = offs_use[atc_pkg::ATC_OFFS_SIGN];
        next_ana.ts_range     = cal_use[atc_pkg::ATC_RANGE_LSB +: 2];
        next_ana.ts_celsius   = cal_use[atc_pkg::ATC_CAL_OFFS];
        next_ana.ts_trim_en   = cal_use[atc_pkg::ATC_CAL_TRIM];
        next_ana.ts_trim      = cal_use[atc_pkg::ATC_TRIM_LSB +: 4];
    end

    always_comb begin
        case (state)
            atc_pkg::ATC_ST_IDLE: begin
                next_state = start_ok ? atc_pkg::ATC_ST_START : atc_pkg::ATC_ST_IDLE;
            end
            atc_pkg::ATC_ST_START: begin
                next_state = atc_pkg::ATC_ST_CONV;
            end
            atc_pkg::ATC_ST_CONV: begin
                next_state = ana_done ? atc_pkg::ATC_ST_IDLE : atc_pkg::ATC_ST_CONV;
            end
            default: begin
                next_state = atc_pkg::ATC_ST_IDLE;
            end
        endcase
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_cfg) begin
            next_prdata[7:0] = {done, cfg};
        end
        if (hit_offs) begin
            next_prdata[3:0] = offs;
        end
        if (hit_result) begin
            next_prdata[7:0] = result;
        end
        if (hit_cal) begin
            next_prdata[7:0] = cal;
        end
        if (hit_tvoffs) begin
            next_prdata[7:0] = tvoffs;
        end
        if (hit_status) begin
            next_prdata[0] = status[0];
        end
        if (hit_mask) begin
            next_prdata[0] = mask[0];
        end
    end

    // Read data and error are registered in the setup cycle, so no wait state is needed
    assign pready    = 1'b1;
    assign ana_start = (state == atc_pkg::ATC_ST_START);
    assign irq       = |(status & mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= bad_access;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg    <= atc_pkg::ATC_RST_CFG;
            offs   <= atc_pkg::ATC_RST_OFFS;
            cal    <= atc_pkg::ATC_RST_CAL;
            tvoffs <= atc_pkg::ATC_RST_TVOFFS;
            mask   <= atc_pkg::ATC_RST_MASK;
        end else begin
            cfg    <= cfg_use;
            offs   <= offs_use;
            cal    <= cal_use;
            tvoffs <= wr_tvoffs ? pwdata[7:0] : tvoffs;
            mask   <= wr_mask ? pwdata[0:0] : mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= atc_pkg::ATC_ST_IDLE;
            ana   <= '0;
        end else begin
            state <= next_state;
            if (start_ok) begin
                ana <= next_ana;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done   <= 1'b0;
            result <= atc_pkg::ATC_RST_RESULT;
        end else if (conv_end) begin
            done   <= 1'b1;
            result <= next_result;
        end else if (start_ok) begin
            done   <= 1'b0;
        end
    end

    // Completion event wins over a same-cycle clear by write-one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= atc_pkg::ATC_RST_STATUS;
        end else if (conv_end) begin
            status[atc_pkg::ATC_ST_DONE] <= 1'b1;
        end else if (wr_status & pwdata[atc_pkg::ATC_ST_DONE]) begin
            status[atc_pkg::ATC_ST_DONE] <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_START_SEQUENCE: assert property (start_ok |=> ana_start && !done ##1 !ana_start)
        else $error("start did not raise one analog start pulse");

    AST_START_ONLY_IDLE: assert property (ana_start |-> $past(start_ok))
        else $error("analog start without accepted request");

    AST_BUSY_START_DROPPED: assert property (start_req && !start_ok
                                             |=> !ana_start && $stable(ana))
        else $error("start while busy reached the analog side");

    AST_DONE_READBACK: assert property (setup && !pwrite && hit_cfg
                                        |=> prdata[7] == $past(done))
        else $error("completion bit read back wrong");

    AST_DONE_RISE: assert property ($rose(done) |-> $past(conv_end))
        else $error("completion set without converter answer");

    AST_DONE_HOLD: assert property (done && !start_ok |=> done)
        else $error("completion cleared without a new start");

    AST_BUSY_READS_ZERO: assert property ((state != atc_pkg::ATC_ST_IDLE) |-> !done)
        else $error("completion set while conversion running");

    AST_SOURCE_LATCH: assert property (start_ok
                                       |=> ana.src == $past(sel_use)
                                       && ana.diff_mode == ($past(sel_use) inside {3'b100,
                                          3'b101, 3'b110}))
        else $error("source selection not taken at start");

    AST_CFG_STORE: assert property (wr_cfg |=> cfg == $past(pwdata[6:0]))
        else $error("configuration fields not stored");

    AST_SETTINGS_HELD: assert property (!start_ok |=> $stable(ana))
        else $error("analog settings changed without a start");

    AST_REFERENCE: assert property (start_ok && !ref_use[1]
                                    |=> ana.ref_bandgap && !ana.ref_third && !ana.ref_half)
        else $error("bandgap reference not chosen");

    AST_REF_THIRD: assert property (start_ok && ref_use == 2'b10
                                    |=> !ana.ref_bandgap && ana.ref_third && !ana.ref_half)
        else $error("third of supply reference not chosen");

    AST_REF_HALF: assert property (start_ok && ref_use == 2'b11
                                   |=> !ana.ref_bandgap && !ana.ref_third && ana.ref_half)
        else $error("half of supply reference not chosen");

    AST_FULL_SCALE: assert property (start_ok
                                     |=> ana.fs_coef_high == $past(ref_use[0])
                                     && ana.gain == $past(gain_use))
        else $error("full scale settings not taken");

    AST_AMP_OFFSET: assert property (start_ok
                                     |=> {ana.offs_neg, ana.offs_mag} == $past(offs_use))
        else $error("amplifier offset not taken");

    AST_RESULT_FRESH: assert property (conv_end && !is_temp
                                       |=> done && result == $past(ana_code))
        else $error("result not updated with completion");

    AST_RESULT_HELD: assert property (!conv_end |=> $stable(result))
        else $error("result changed without a conversion");

    AST_RESULT_READBACK: assert property (setup && !pwrite && hit_result
                                          |=> prdata == {24'h000000, $past(result)})
        else $error("result read back wrong");

    AST_RESULT_RO: assert property (setup && pwrite && hit_result |=> pslverr)
        else $error("write to result not refused");

    AST_SENSOR_CAL: assert property (start_ok
                                     |=> ana.ts_celsius == $past(cal_use[5])
                                     && ana.ts_trim_en == $past(cal_use[4])
                                     && ana.ts_trim == $past(cal_use[3:0])
                                     && ana.ts_range == $past(cal_use[7:6]))
        else $error("sensor calibration not taken");

    AST_TEMP_OFFSET: assert property (conv_end && is_temp && tvoffs == 8'h00
                                      |=> result == $past(ana_code))
        else $error("zero offset altered temperature");

    AST_TEMP_FLOOR: assert property (conv_end && is_temp && tvoffs[7]
                                     && ({1'b0, ana_code} < {1'b0, (~tvoffs + 8'h01)})
                                     |=> result == 8'h00)
        else $error("negative offset did not saturate at zero");

    AST_TEMP_CEILING: assert property (conv_end && is_temp && !tvoffs[7]
                                       && ({1'b0, ana_code} + {1'b0, tvoffs} > 9'h0ff)
                                       |=> result == 8'hff)
        else $error("positive offset did not saturate at full code");

    AST_TEMP_SUM: assert property (conv_end && is_temp && tvoffs[7]
                                   && (ana_code >= (~tvoffs + 8'h01))
                                   |=> result == $past(ana_code) + $past(tvoffs))
        else $error("negative offset not added to temperature");

    AST_STATUS_SET: assert property (conv_end |=> status[0] ##0 (irq == mask[0]))
        else $error("completion event not recorded");

    AST_STATUS_CLEAR: assert property (wr_status && pwdata[0] && !conv_end |=> !status[0])
        else $error("status bit not cleared by write of one");

    AST_STATUS_HOLD: assert property (status[0] && !(wr_status && pwdata[0]) |=> status[0])
        else $error("status bit lost without a clear");

    AST_IRQ_MASKED: assert property (!mask[0] |-> !irq)
        else $error("interrupt raised while masked");

    AST_WRITE_READS_ZERO: assert property (setup && pwrite |=> prdata == 32'h0000_0000)
        else $error("read data not zero on a write");

    AST_UNALIGNED_ERR: assert property (setup && (paddr[1:0] != 2'b00) |=> pslverr)
        else $error("unaligned access not refused");

    AST_CFG_NO_ERR: assert property (setup && hit_cfg |=> !pslverr)
        else $error("configuration access refused");

    CVR_SINGLE_ENDED: cover property (start_ok && sel_use == 3'b001 ##[1:50] conv_end);
    CVR_TEMP_OFFSET: cover property (conv_end && is_temp && tvoffs != 8'h00);
    CVR_SET_CLEAR: cover property (conv_end && wr_status && pwdata[0]);
    CVR_BUSY_START: cover property (start_req && !start_ok);
endmodule

// File: core/atc_pkg.sv
// Constants, types and register map of the auxiliary converter control block
package atc_pkg;
    localparam logic [5:0] ATC_IDX_CFG     = 6'h0f;
    localparam logic [5:0] ATC_IDX_OFFS    = 6'h10;
    localparam logic [5:0] ATC_IDX_RESULT  = 6'h11;
    localparam logic [5:0] ATC_IDX_CAL     = 6'h12;
    localparam logic [5:0] ATC_IDX_TVOFFS  = 6'h13;
    localparam logic [5:0] ATC_IDX_STATUS  = 6'h20;
    localparam logic [5:0] ATC_IDX_MASK    = 6'h21;

    localparam int ATC_CFG_START = 7;
    localparam int ATC_SEL_LSB   = 4;
    localparam int ATC_REF_LSB   = 2;
    localparam int ATC_GAIN_LSB  = 0;
    localparam int ATC_OFFS_SIGN = 3;
    localparam int ATC_RANGE_LSB = 6;
    localparam int ATC_CAL_OFFS  = 5;
    localparam int ATC_CAL_TRIM  = 4;
    localparam int ATC_TRIM_LSB  = 0;
    localparam int ATC_ST_DONE   = 0;

    localparam logic [6:0] ATC_RST_CFG    = 7'h00;
    localparam logic [3:0] ATC_RST_OFFS   = 4'h0;
    localparam logic [7:0] ATC_RST_RESULT = 8'h00;
    localparam logic [7:0] ATC_RST_CAL    = 8'h20;
    localparam logic [7:0] ATC_RST_TVOFFS = 8'h00;
    localparam logic [0:0] ATC_RST_STATUS = 1'h0;
    localparam logic [0:0] ATC_RST_MASK   = 1'h0;

    typedef enum logic [2:0] {
        ATC_SRC_TEMP  = 3'b000,
        ATC_SRC_GPIO0 = 3'b001,
        ATC_SRC_GPIO1 = 3'b010,
        ATC_SRC_GPIO2 = 3'b011,
        ATC_SRC_D01   = 3'b100,
        ATC_SRC_D12   = 3'b101,
        ATC_SRC_D02   = 3'b110,
        ATC_SRC_GND   = 3'b111
    } atc_src_e;

    typedef enum logic [1:0] {
        ATC_ST_IDLE  = 2'b00,
        ATC_ST_START = 2'b01,
        ATC_ST_CONV  = 2'b10
    } atc_state_e;

    typedef struct packed {
        atc_src_e   src;
        logic       diff_mode;
        logic       ref_bandgap;
        logic       ref_third;
        logic       ref_half;
        logic       fs_coef_high;
        logic [1:0] gain;
        logic [2:0] offs_mag;
        logic       offs_neg;
        logic [1:0] ts_range;
        logic       ts_celsius;
        logic       ts_trim_en;
        logic [3:0] ts_trim;
    } atc_ana_s;
endpackage

// File: test/atc_conv_model.sv
// Behavioural model of the analog converter facing the control block
`timescale 1ns/1ns
module atc_conv_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ana_start,
    input  wire logic [7:0] delay,
    input  wire logic [7:0] code,
    output logic            ana_done,
    output logic [7:0]      ana_code
);
    logic [7:0] cnt;

    // Code is only valid with done; otherwise it toggles so stale values never match
    // GPIO sources are taken as already switched to analog input by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= 8'h00;
            ana_done <= 1'b0;
            ana_code <= 8'h00;
        end else begin
            ana_done <= (cnt == 8'h01);
            ana_code <= (cnt == 8'h01) ? code : ~ana_code;
            if (ana_start) begin
                cnt <= delay;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

// File: test/atc_ctrl_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module atc_ctrl_bench;
    localparam logic [7:0] A_CFG = {atc_pkg::ATC_IDX_CFG, 2'b00};
    localparam logic [7:0] A_OFS = {atc_pkg::ATC_IDX_OFFS, 2'b00};
    localparam logic [7:0] A_RES = {atc_pkg::ATC_IDX_RESULT, 2'b00};
    localparam logic [7:0] A_CAL = {atc_pkg::ATC_IDX_CAL, 2'b00};
    localparam logic [7:0] A_TV  = {atc_pkg::ATC_IDX_TVOFFS, 2'b00};
    localparam logic [7:0] A_ST  = {atc_pkg::ATC_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_MSK = {atc_pkg::ATC_IDX_MASK, 2'b00};
    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [7:0]        paddr   = 8'h00;
    logic [31:0]       pwdata  = 32'h0;
    logic [7:0]        m_dly   = 8'h02;
    logic [7:0]        m_code  = 8'h00;
    logic [7:0]        cal_v   = 8'h20;
    logic [7:0]        offs_v  = 8'h00;
    logic [7:0]        tv_v    = 8'h00;
    logic [31:0]       rd;
    logic              er;
    wire  [31:0]       prdata;
    wire               pready;
    wire               pslverr;
    wire               ana_start;
    wire               ana_done;
    wire  [7:0]        ana_code;
    wire               irq;
    atc_pkg::atc_ana_s ana;
    int                err_total = 0;
    int                n_checks  = 0;
    int                n_start   = 0;
    int                cyc       = 0;

    atc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ana(ana), .ana_start(ana_start), .ana_done(ana_done),
        .ana_code(ana_code), .irq(irq));
    atc_conv_model model_u (.pclk(pclk), .presetn(presetn), .ana_start(ana_start),
        .delay(m_dly), .code(m_code), .ana_done(ana_done), .ana_code(ana_code));

    always #5 pclk = ~pclk;

    // Hang guard well above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (ana_start === 1'b1) begin
            n_start++;
        end
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    task summarize;
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state limit here: only the cycle ceiling ends a stuck transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write error", er, 1'b0);
    endtask

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
        chk("read error", er, ee);
    endtask

    task poll;
        int k;
        k = 0;
        do begin
            apb(1'b0, A_CFG, 32'h0);
            k++;
        end while (rd[7] !== 1'b1 && k < 40);
    endtask

    function automatic logic [7:0] exp_res(logic [2:0] s, logic [7:0] c, logic [7:0] t);
        int v;
        v = int'(c) + int'($signed(t));
        if (s != 3'b000) return c;
        return (v > 255) ? 8'hff : (v < 0) ? 8'h00 : v[7:0];
    endfunction

    task conv(input logic [2:0] s, input logic [1:0] rf, input logic [1:0] g,
              input logic [7:0] dl, input logic [7:0] cd);
        int n0;
        n0 = n_start;
        m_dly  <= dl;
        m_code <= cd;
        apb(1'b1, A_CFG, {24'h0, 1'b1, s, rf, g});
        // Settings land at the write edge, so look half a cycle later
        @(negedge pclk);
        chk("src", ana.src, s);
        chk("diff", ana.diff_mode, s[2] & ~&s);
        chk("ref", {ana.ref_bandgap, ana.ref_third, ana.ref_half},
            {~rf[1], rf == 2'b10, rf == 2'b11});
        chk("coef", {ana.fs_coef_high, ana.gain}, {rf[0], g});
        chk("amp offset", {ana.offs_neg, ana.offs_mag}, offs_v[3:0]);
        chk("range", ana.ts_range, cal_v[7:6]);
        chk("celsius", ana.ts_celsius, cal_v[5]);
        chk("trim", {ana.ts_trim_en, ana.ts_trim}, cal_v[4:0]);
        if (dl > 8'h05) begin
            rchk("busy", A_CFG, {24'h0, 1'b0, s, rf, g}, 1'b0);
        end
        poll();
        chk("done", rd, {24'h0, 1'b1, s, rf, g});
        chk("starts", n_start - n0, 1);
        rchk("result", A_RES, exp_res(s, cd, tv_v), 1'b0);
    endtask

    task t_reset;
        rchk("cfg", A_CFG, 32'h0, 1'b0);
        rchk("offs", A_OFS, 32'h0, 1'b0);
        rchk("res", A_RES, 32'h0, 1'b0);
        rchk("cal", A_CAL, 32'h20, 1'b0);
        rchk("tv", A_TV, 32'h0, 1'b0);
        rchk("mask", A_MSK, 32'h0, 1'b0);
    endtask

    task t_refuse;
        rchk("unmapped", 8'h00, 32'h0, 1'b1);
        rchk("unaligned", 8'h3d, 32'h0, 1'b1);
        apb(1'b1, A_RES, 32'haa);
        chk("ro error", er, 1'b1);
        rchk("ro kept", A_RES, 32'h0, 1'b0);
    endtask

    task t_regs;
        offs_v = 8'h0d;
        cal_v  = 8'hb7;
        tv_v   = 8'h05;
        wr(A_OFS, 32'hfd);
        rchk("offs rw", A_OFS, 32'h0d, 1'b0);
        wr(A_CAL, {24'h0, cal_v});
        rchk("cal rw", A_CAL, {24'h0, cal_v}, 1'b0);
        wr(A_TV, {24'h0, tv_v});
        rchk("tv rw", A_TV, {24'h0, tv_v}, 1'b0);
    endtask

    // Prompt and slow answers alternate; every source and reference code is set
    task t_sources;
        for (int i = 0; i < 8; i++) begin
            conv(i[2:0], i[1:0], i[2:1], i[0] ? 8'h01 : 8'h09, 8'h30 + i[7:0]);
        end
    endtask

    task t_sat;
        offs_v = 8'h02;
        cal_v  = 8'h4a;
        wr(A_OFS, 32'h02);
        wr(A_CAL, 32'h4a);
        conv(3'b000, 2'b00, 2'b00, 8'h09, 8'hfe);
        tv_v = 8'hfe;
        wr(A_TV, 32'hfe);
        cal_v = 8'h15;
        wr(A_CAL, 32'h15);
        conv(3'b000, 2'b01, 2'b10, 8'h09, 8'h01);
        conv(3'b000, 2'b11, 2'b01, 8'h02, 8'h80);
    endtask

    // A second start while converting must not reach the analog side
    task t_busy;
        int n0;
        n0 = n_start;
        m_dly  <= 8'h14;
        m_code <= 8'h5a;
        apb(1'b1, A_CFG, 32'h9b);
        apb(1'b1, A_CFG, 32'he4);
        chk("busy src", {ana.src, ana.ref_third}, {3'b001, 1'b1});
        poll();
        chk("busy cfg", rd, 32'he4);
        chk("busy starts", n_start - n0, 1);
        rchk("busy res", A_RES, 32'h5a, 1'b0);
    endtask

    task t_irq;
        cal_v = 8'hd0;
        wr(A_CAL, 32'hd0);
        wr(A_MSK, 32'h1);
        conv(3'b001, 2'b00, 2'b01, 8'h03, 8'h77);
        chk("irq set", irq, 1'b1);
        wr(A_MSK, 32'h0);
        @(posedge pclk);
        chk("irq masked", irq, 1'b0);
        wr(A_MSK, 32'h1);
        @(posedge pclk);
        chk("irq unmasked", irq, 1'b1);
        rchk("status", A_ST, 32'h1, 1'b0);
        wr(A_ST, 32'h1);
        @(posedge pclk);
        chk("irq cleared", irq, 1'b0);
        rchk("status clr", A_ST, 32'h0, 1'b0);
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_refuse();
        t_regs();
        t_sources();
        t_sat();
        t_busy();
        t_irq();
        summarize();
    end
endmodule
